// ### rtl/uxc_pkg.sv
package uxc_pkg;

  // Register addresses on the two-wire bus
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_SFR1 = 8'h14;
  localparam logic [7:0] ADDR_SFR2_A = 8'h16;
  localparam logic [7:0] ADDR_SFR2_B = 8'h17;
  localparam logic [7:0] ADDR_SFR2_ALT_A = 8'h10;
  localparam logic [7:0] ADDR_SFR2_ALT_B = 8'h11;

  // First control register fields
  localparam int CR1_SPEED = 0;
  localparam int CR1_SUSPEND = 1;
  localparam int CR1_ENC = 2;
  localparam int CR1_OE_INT_EN = 5;
  localparam int CR1_UART_EN = 6;

  // First special-function register fields
  localparam int SF1_INT_SDWN = 0;
  localparam int SF1_SRC_CTL = 1;
  localparam int SF1_DMINUS_DIR = 3;
  localparam int SF1_DPLUS_DIR = 4;
  localparam int SF1_BUF_EN = 7;

  // Second special-function register fields
  localparam int SF2_SDWN = 0;
  localparam int SF2_IRQ_PP = 1;

  // Power-up values
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] SF1_RST = 8'h00;
  localparam logic [7:0] SF2_RST = 8'h01;

  // Timing: system clock and the fastest serial clock served
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int SCL_PERIOD_CYC =
    (SCL_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SCL_MIN_OVERSAMPLE = 4;

  // Edge rates selected by the speed control
  localparam int LOW_SPEED_KBPS = 1500;
  localparam int FULL_SPEED_KBPS = 12000;

  // Register image carried as one bundle
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] sfr1;
    logic [7:0] sfr2;
  } uxc_regs_t;

  // One queued register write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } uxc_wr_t;

  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } uxc_i2c_st_t;

endpackage : uxc_pkg

// ### rtl/uxc_xcvr_ctl.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Write queue between the serial slave and the register file
module uxc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refused at elaboration: the wrap-bit pointers need a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("uxc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign o_in_ready = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_r != rd_ptr_r;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule : uxc_fifo

////////////////////////////////////////////////////////////////////////
// Transceiver mode and data-path control with its register file
module uxc_xcvr_ctl #(
  parameter bit OPERATIONAL_AT_POWER_UP = 1'b1,
  parameter logic [6:0] SLAVE_ADDR = 7'h2d, // Arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_reset_n,
  // Two-wire register bus
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register write queue stall
  input wire logic i_cfg_hold,
  // Direction / shared interrupt pin
  input wire logic i_oe_int_in,
  output logic o_oe_int_out,
  output logic o_oe_int_oe,
  // System data pins
  input wire logic i_sys_data_pin_a,
  output logic o_sys_data_pin_a,
  output logic o_sys_data_pin_a_oe,
  input wire logic i_sys_data_pin_b,
  output logic o_sys_data_pin_b,
  output logic o_sys_data_pin_b_oe,
  // USB lines
  input wire logic i_dp,
  output logic o_dp,
  output logic o_dp_oe,
  input wire logic i_dm,
  output logic o_dm,
  output logic o_dm_oe,
  // Mode pins and interrupt event
  input wire logic i_suspend_pin,
  input wire logic i_speed_pin,
  input wire logic i_irq_event,
  // Receive outputs
  output logic o_diff_rx_out,
  output logic o_dplus_echo,
  output logic o_dminus_echo,
  // Mode status and block enables
  output logic o_full_speed,
  output logic o_suspend,
  output logic o_xcvr_en,
  output logic o_comp_en,
  output logic o_id_det_en,
  output logic o_sess_vld_en,
  output logic o_regulator_en,
  output uxc_pkg::uxc_regs_t o_regs
);
  import uxc_pkg::*;

  // Refused at elaboration: edge detection needs several samples per bit
  if (SCL_PERIOD_CYC < SCL_MIN_OVERSAMPLE) begin : g_clk_chk
    $error("system clock too slow to oversample the serial clock");
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst || !i_reset_n);

  //////////////////////////////////////////////////////////////////////
  // Serial slave
  uxc_i2c_st_t st_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [3:0] cnt_r;
  logic [1:0] phase_r; // 0 device address, 1 register address, 2 data
  logic rd_r;
  logic mack_r;
  logic [7:0] ptr_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic ack_ok;
  logic [7:0] rd_data;
  uxc_wr_t wr_in;
  uxc_wr_t wr_out;
  logic wr_valid;
  logic wr_ready;
  logic wr_push;
  logic wr_out_valid;
  uxc_regs_t regs_r;

  // Pins are already synchronous, one stage gives the edge history
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= i_scl;
      sda_q_r <= i_sda_in;
    end
  end

  assign scl_rise = i_scl && !scl_q_r;
  assign scl_fall = !i_scl && scl_q_r;
  assign start_c = i_scl && scl_q_r && sda_q_r && !i_sda_in;
  assign stop_c = i_scl && scl_q_r && !sda_q_r && i_sda_in;

  // Read-back decode; aliases only in the operational variant
  always_comb begin
    if (ptr_r == ADDR_CTRL1) begin
      rd_data = regs_r.ctrl1;
    end else if (ptr_r == ADDR_SFR1) begin
      rd_data = regs_r.sfr1;
    end else if (ptr_r == ADDR_SFR2_A || ptr_r == ADDR_SFR2_B) begin
      rd_data = regs_r.sfr2;
    end else if (OPERATIONAL_AT_POWER_UP &&
                 (ptr_r == ADDR_SFR2_ALT_A || ptr_r == ADDR_SFR2_ALT_B)) begin
      rd_data = regs_r.sfr2;
    end else begin
      rd_data = 8'h00;
    end
  end

  // A data byte is refused when the write queue is full
  always_comb begin
    if (phase_r == 2'd0) begin
      ack_ok = sh_r[7:1] == SLAVE_ADDR;
    end else if (phase_r == 2'd2) begin
      ack_ok = wr_ready;
    end else begin
      ack_ok = 1'b1;
    end
  end

  assign wr_in = '{addr: ptr_r, data: sh_r};
  assign wr_valid = (st_r == ST_RX) && scl_fall && (cnt_r == 4'd8) &&
                    (phase_r == 2'd2);
  assign wr_push = wr_valid && wr_ready;

  // Byte-level state machine; start and stop override any state
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'd0;
      phase_r <= 2'd0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
    end else if (start_c) begin
      st_r <= ST_RX;
      cnt_r <= 4'd0;
      phase_r <= 2'd0;
    end else if (stop_c) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise && cnt_r < 4'd8) begin
            sh_r <= {sh_r[6:0], i_sda_in};
            cnt_r <= cnt_r + 4'd1;
          end else if (scl_fall && cnt_r == 4'd8) begin
            cnt_r <= 4'd0;
            st_r <= ack_ok ? ST_ACK : ST_IDLE;
            if (phase_r == 2'd0) begin
              rd_r <= sh_r[0];
              phase_r <= 2'd1;
            end else if (phase_r == 2'd1) begin
              ptr_r <= sh_r;
              phase_r <= 2'd2;
            end else if (ack_ok) begin
              ptr_r <= ptr_r + 8'd1; // Burst: next register
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rd_r && phase_r == 2'd1) begin
              st_r <= ST_TX;
              tx_r <= rd_data;
              ptr_r <= ptr_r + 8'd1;
            end else begin
              st_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'd7) begin
              st_r <= ST_MACK;
              cnt_r <= 4'd0;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'd1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_r <= !i_sda_in;
          end else if (scl_fall) begin
            if (mack_r) begin
              st_r <= ST_TX;
              tx_r <= rd_data;
              ptr_r <= ptr_r + 8'd1; // Read burst
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Open-drain data line: only ever pulled low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = (st_r == ST_ACK) || (st_r == ST_TX && !tx_r[7]);

  //////////////////////////////////////////////////////////////////////
  // Write queue; the hold input lets the register update stall
  uxc_fifo #(
    .WIDTH($bits(uxc_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(wr_valid),
    .o_in_ready(wr_ready),
    .i_in_data(wr_in),
    .o_out_valid(wr_out_valid),
    .i_out_ready(!i_cfg_hold),
    .o_out_data(wr_out)
  );

  // Register file; the reset pin acts without the clock
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      regs_r <= '{ctrl1: CR1_RST, sfr1: SF1_RST, sfr2: SF2_RST};
    end else if (i_sys_rst) begin
      regs_r <= '{ctrl1: CR1_RST, sfr1: SF1_RST, sfr2: SF2_RST};
    end else if (wr_out_valid && !i_cfg_hold) begin
      if (wr_out.addr == ADDR_CTRL1) begin
        regs_r.ctrl1 <= wr_out.data;
      end else if (wr_out.addr == ADDR_SFR1) begin
        regs_r.sfr1 <= wr_out.data;
      end else if (wr_out.addr == ADDR_SFR2_A ||
                   wr_out.addr == ADDR_SFR2_B) begin
        regs_r.sfr2 <= wr_out.data;
      end else if (OPERATIONAL_AT_POWER_UP &&
                   (wr_out.addr == ADDR_SFR2_ALT_A ||
                    wr_out.addr == ADDR_SFR2_ALT_B)) begin
        regs_r.sfr2 <= wr_out.data;
      end
    end
  end

  assign o_regs = regs_r;

  //////////////////////////////////////////////////////////////////////
  // Operating mode decode
  logic shutdown;
  logic int_shutdown;
  logic suspend;
  logic full_speed;
  logic enc_data_se0;
  logic uart_mode;
  logic irq_on_oe;
  logic rx_dir;
  logic buf_mode;
  logic active;

  // Shutdown polarity differs between the two variants
  assign shutdown = OPERATIONAL_AT_POWER_UP ? !regs_r.sfr2[SF2_SDWN]
                                            : regs_r.sfr2[SF2_SDWN];
  assign int_shutdown = !shutdown && regs_r.sfr1[SF1_INT_SDWN];
  assign active = !shutdown && !int_shutdown;
  assign suspend = active && (regs_r.sfr1[SF1_SRC_CTL] ?
                   regs_r.ctrl1[CR1_SUSPEND] : i_suspend_pin);
  assign full_speed = regs_r.sfr1[SF1_SRC_CTL] ?
                      regs_r.ctrl1[CR1_SPEED] : i_speed_pin;
  assign enc_data_se0 = regs_r.ctrl1[CR1_ENC];
  assign uart_mode = regs_r.ctrl1[CR1_UART_EN];
  assign irq_on_oe = suspend && regs_r.ctrl1[CR1_OE_INT_EN];
  // While the pin reports interrupts the data path keeps receiving
  assign rx_dir = irq_on_oe || i_oe_int_in;
  assign buf_mode = regs_r.sfr1[SF1_BUF_EN] && enc_data_se0 &&
                    !uart_mode && !i_oe_int_in;

  //////////////////////////////////////////////////////////////////////
  // Data path next values
  logic dp_nxt, dp_oe_nxt, dm_nxt, dm_oe_nxt;
  logic a_nxt, a_oe_nxt, b_nxt, b_oe_nxt;
  logic diff_rx_nxt, oe_int_nxt, oe_int_oe_nxt;
  logic diff_rx_r;

  always_comb begin
    dp_nxt = 1'b0;
    dp_oe_nxt = 1'b0;
    dm_nxt = 1'b0;
    dm_oe_nxt = 1'b0;
    a_nxt = 1'b0;
    a_oe_nxt = 1'b0;
    b_nxt = 1'b0;
    b_oe_nxt = 1'b0;
    // Differential receiver holds its value across SE0
    if (i_dp && !i_dm) begin
      diff_rx_nxt = 1'b1;
    end else if (!i_dp && i_dm) begin
      diff_rx_nxt = 1'b0;
    end else begin
      diff_rx_nxt = diff_rx_r;
    end
    if (!active) begin
      diff_rx_nxt = 1'b0; // Quiet when powered down
    end else if (uart_mode) begin
      a_nxt = i_dp;
      a_oe_nxt = 1'b1;
      dm_nxt = i_sys_data_pin_b;
      dm_oe_nxt = 1'b1;
    end else if (buf_mode) begin
      // Direction bit 0 drives the line, 1 drives the system pin
      if (regs_r.sfr1[SF1_DPLUS_DIR]) begin
        a_nxt = i_dp;
        a_oe_nxt = 1'b1;
      end else begin
        dp_nxt = i_sys_data_pin_a;
        dp_oe_nxt = 1'b1;
      end
      if (regs_r.sfr1[SF1_DMINUS_DIR]) begin
        b_nxt = i_dm;
        b_oe_nxt = 1'b1;
      end else begin
        dm_nxt = i_sys_data_pin_b;
        dm_oe_nxt = 1'b1;
      end
    end else if (!rx_dir) begin
      dp_oe_nxt = 1'b1;
      dm_oe_nxt = 1'b1;
      if (enc_data_se0) begin
        dp_nxt = i_sys_data_pin_a && !i_sys_data_pin_b;
        dm_nxt = !i_sys_data_pin_a && !i_sys_data_pin_b;
      end else begin
        dp_nxt = i_sys_data_pin_a;
        dm_nxt = i_sys_data_pin_b;
      end
    end else begin
      a_oe_nxt = 1'b1;
      b_oe_nxt = 1'b1;
      if (enc_data_se0) begin
        a_nxt = suspend ? i_dp : diff_rx_nxt;
        b_nxt = !i_dp && !i_dm;
      end else begin
        a_nxt = i_dp;
        b_nxt = i_dm;
      end
    end
    if (suspend) begin
      diff_rx_nxt = 1'b0;
    end
  end

  // Shared pin as an interrupt, active low, style by register
  always_comb begin
    oe_int_nxt = 1'b1;
    oe_int_oe_nxt = 1'b0;
    if (irq_on_oe) begin
      if (regs_r.sfr2[SF2_IRQ_PP]) begin
        oe_int_nxt = !i_irq_event;
        oe_int_oe_nxt = 1'b1;
      end else begin
        oe_int_nxt = 1'b0;
        oe_int_oe_nxt = i_irq_event;
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_dp <= 1'b0;
      o_dp_oe <= 1'b0;
      o_dm <= 1'b0;
      o_dm_oe <= 1'b0;
      o_sys_data_pin_a <= 1'b0;
      o_sys_data_pin_a_oe <= 1'b0;
      o_sys_data_pin_b <= 1'b0;
      o_sys_data_pin_b_oe <= 1'b0;
      diff_rx_r <= 1'b0;
      o_dplus_echo <= 1'b0;
      o_dminus_echo <= 1'b0;
      o_oe_int_out <= 1'b1;
      o_oe_int_oe <= 1'b0;
    end else begin
      o_dp <= dp_nxt;
      o_dp_oe <= dp_oe_nxt;
      o_dm <= dm_nxt;
      o_dm_oe <= dm_oe_nxt;
      o_sys_data_pin_a <= a_nxt;
      o_sys_data_pin_a_oe <= a_oe_nxt;
      o_sys_data_pin_b <= b_nxt;
      o_sys_data_pin_b_oe <= b_oe_nxt;
      diff_rx_r <= diff_rx_nxt;
      o_dplus_echo <= active && i_dp;
      o_dminus_echo <= active && i_dm;
      o_oe_int_out <= oe_int_nxt;
      o_oe_int_oe <= oe_int_oe_nxt;
    end
  end

  assign o_diff_rx_out = diff_rx_r;

  // Registered status and block enables
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_full_speed <= 1'b0;
      o_suspend <= 1'b0;
      o_xcvr_en <= 1'b0;
      o_comp_en <= 1'b0;
      o_id_det_en <= 1'b0;
      o_sess_vld_en <= 1'b0;
      o_regulator_en <= 1'b0;
    end else begin
      o_full_speed <= full_speed;
      o_suspend <= suspend;
      o_xcvr_en <= active;
      o_comp_en <= active;
      o_id_det_en <= !shutdown;
      o_sess_vld_en <= !shutdown;
      o_regulator_en <= active;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_byte_in;
    (st_r == ST_RX && scl_fall && cnt_r == 4'd8 && phase_r == 2'd2 &&
     wr_ready);
  endsequence
  sequence s_ack_driven;
    ##1 (st_r == ST_ACK && o_sda_oe);
  endsequence

  a_burst_ack: assert property (s_byte_in |-> s_ack_driven)
    else $error("accepted data byte not acknowledged");
  a_shutdown_quiet: assert property (shutdown |=>
    !o_xcvr_en && !o_id_det_en && !o_dp_oe && !o_dm_oe)
    else $error("circuitry active in shutdown");
  a_int_sdwn_keep: assert property (int_shutdown |=>
    o_id_det_en && o_sess_vld_en && !o_xcvr_en)
    else $error("interrupt shutdown enables wrong");
  a_sw_suspend: assert property (
    (active && regs_r.sfr1[SF1_SRC_CTL] && regs_r.ctrl1[CR1_SUSPEND])
    |=> o_suspend && !o_diff_rx_out)
    else $error("register suspend not entered");
  a_se0_force: assert property (
    (active && !uart_mode && !buf_mode && !rx_dir && enc_data_se0 &&
     i_sys_data_pin_b) |=> (o_dp_oe && !o_dp && !o_dm))
    else $error("SE0 not driven");
  a_perline_tx: assert property (
    (active && !uart_mode && !buf_mode && !rx_dir && !enc_data_se0)
    |=> (o_dp == $past(i_sys_data_pin_a) &&
         o_dm == $past(i_sys_data_pin_b)))
    else $error("per-line transmit mismatch");
  a_se0_flag_rx: assert property (
    (active && !uart_mode && !buf_mode && rx_dir && enc_data_se0)
    |=> (o_sys_data_pin_b == ($past(!i_dp) && $past(!i_dm))))
    else $error("receive SE0 flag wrong");
  a_diff_rx_hold: assert property (
    (active && !suspend && !i_dp && !i_dm) |=> $stable(o_diff_rx_out))
    else $error("receive output changed on SE0");
  a_speed_src: assert property (
    regs_r.sfr1[SF1_SRC_CTL] |=>
    o_full_speed == $past(regs_r.ctrl1[CR1_SPEED]))
    else $error("speed not from register");
  a_irq_style: assert property (
    (irq_on_oe && !regs_r.sfr2[SF2_IRQ_PP] && i_irq_event)
    |=> (o_oe_int_oe && !o_oe_int_out))
    else $error("open-drain interrupt not pulled low");

endmodule : uxc_xcvr_ctl

// ### testbench/uxc_sie_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Host-side two-wire master; SDA is open drain, so only pulls low
module uxc_sie_model #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2d // Arbitrary value
) (
  // Clock
  input wire logic i_sys_clk,
  // Bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Bus idles released and high
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // Quarter bit; kept short to keep the run brief, still oversampled
  task automatic q;
    repeat (4) @(negedge i_sys_clk);
  endtask : q

  // Data changes only while SCL is low, sampled in the high phase
  task automatic bit_io(input logic b, output logic seen);
    o_sda_oe = ~b;
    q();
    o_scl = 1'b1;
    q();
    seen = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask : bit_io

  // MSB first, then the acknowledge slot with SDA released
  task automatic byte_io(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_io

  // Start: SDA falls with SCL high, then SCL goes low
  task automatic bus_start;
    o_sda_oe = 1'b1;
    q();
    o_scl = 1'b0;
  endtask : bus_start

  // Stop: SDA rises with SCL high, bus left released
  task automatic bus_stop;
    o_sda_oe = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_oe = 1'b0;
    q();
  endtask : bus_stop

  // Burst write of n copies of d from register ra; counts all acks
  task automatic wr(input logic [7:0] ra, input logic [7:0] d,
                    input int n, output int acks);
    logic a;
    acks = 0;
    bus_start();
    byte_io({SLAVE_ADDR, 1'b0}, a);
    acks += a;
    byte_io(ra, a);
    acks += a;
    for (int i = 0; i < n; i++) begin
      byte_io(d, a);
      acks += a;
    end
    bus_stop();
  endtask : wr

  // One-byte read: pointer set, repeated start, byte back, then NACK
  task automatic rd(input logic [7:0] ra, output logic [7:0] d,
                    output int acks);
    logic a;
    acks = 0;
    bus_start();
    byte_io({SLAVE_ADDR, 1'b0}, a);
    acks += a;
    byte_io(ra, a);
    acks += a;
    q();
    o_scl = 1'b1; // SDA already released for the repeated start
    q();
    bus_start();
    byte_io({SLAVE_ADDR, 1'b1}, a);
    acks += a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, a);
    bus_stop();
  endtask : rd
endmodule : uxc_sie_model

// ### testbench/uxc_xcvr_ctl_tb.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module uxc_xcvr_ctl_tb;
  import uxc_pkg::*;
  logic i_sys_clk, i_sys_rst, i_reset_n, i_cfg_hold, i_oe_int_in;
  logic i_sys_data_pin_a, i_sys_data_pin_b, i_dp, i_dm, i_irq_event;
  logic i_suspend_pin, i_speed_pin, o_sda_out, o_sda_oe, o_oe_int_out;
  logic o_oe_int_oe, o_sys_data_pin_a, o_sys_data_pin_a_oe, o_dp, o_dm;
  logic o_sys_data_pin_b, o_sys_data_pin_b_oe, o_dp_oe, o_dm_oe;
  logic o_diff_rx_out, o_dplus_echo, o_dminus_echo, o_full_speed;
  logic o_suspend, o_xcvr_en, o_comp_en, o_id_det_en, o_sess_vld_en;
  logic o_regulator_en;
  uxc_regs_t o_regs;
  wire logic i_scl;
  wire logic m_sda_oe;
  int err_total = 0;
  int n_tests = 0;
  int a;
  logic [7:0] rv;
  // Pulled-up SDA: low when either party pulls
  wire logic i_sda_in = ~(o_sda_oe | m_sda_oe);

  // 125 MHz clock
  initial i_sys_clk = 1'b0;
  always #4 i_sys_clk = ~i_sys_clk;

  uxc_xcvr_ctl #(.FIFO_DEPTH(8)) DUT (.i_sys_clk, .i_sys_rst, .i_reset_n,
    .i_scl, .i_sda_in, .o_sda_out, .o_sda_oe, .i_cfg_hold, .i_oe_int_in,
    .o_oe_int_out, .o_oe_int_oe, .i_sys_data_pin_a, .o_sys_data_pin_a,
    .o_sys_data_pin_a_oe, .i_sys_data_pin_b, .o_sys_data_pin_b,
    .o_sys_data_pin_b_oe, .i_dp, .o_dp, .o_dp_oe, .i_dm, .o_dm, .o_dm_oe,
    .i_suspend_pin, .i_speed_pin, .i_irq_event, .o_diff_rx_out,
    .o_dplus_echo, .o_dminus_echo, .o_full_speed, .o_suspend, .o_xcvr_en,
    .o_comp_en, .o_id_det_en, .o_sess_vld_en, .o_regulator_en, .o_regs);
  uxc_sie_model M (.i_sys_clk, .i_sda(i_sda_in), .o_scl(i_scl),
    .o_sda_oe(m_sda_oe));

  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // Compare seen against expected
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Let registered outputs settle
  task automatic settle;
    repeat (4) @(negedge i_sys_clk);
  endtask : settle

  // Single register write, all three bytes acknowledged
  task automatic w(input logic [7:0] ra, input logic [7:0] d);
    M.wr(ra, d, 1, a);
    chk(a, 3);
    settle();
  endtask : w

  // Hang guard, well past the expected run length
  initial begin
    #500000;
    err_total++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {i_sys_rst, i_reset_n, i_oe_int_in} = 3'b110;
    {i_cfg_hold, i_sys_data_pin_a, i_sys_data_pin_b, i_dp, i_dm} = 5'h00;
    {i_irq_event, i_suspend_pin, i_speed_pin} = 3'b000;
    repeat (5) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    settle();
    chk(o_regs, 24'h000001);
    chk({o_sda_out, o_xcvr_en}, 2'b01);
    w(8'h10, 8'h00);
    chk(o_regs[7:0], 8'h00);
    chk({o_xcvr_en, o_comp_en, o_regulator_en, o_id_det_en}, 0);
    w(8'h16, 8'h01);
    chk(o_xcvr_en, 1);
    M.rd(8'h11, rv, a);
    chk({a[7:0], rv}, 16'h0301);
    w(8'h14, 8'h01);
    chk({o_xcvr_en, o_id_det_en, o_sess_vld_en},
      3'b011);
    // Burst from an unmapped place; pointer steps onto sfr1
    M.wr(8'h13, 8'h02, 2, a);
    settle();
    chk({a[7:0], o_regs[15:8]}, 16'h0402);
    {i_speed_pin, i_suspend_pin} = 2'b11;
    w(8'h04, 8'h00);
    chk({o_full_speed, o_suspend}, 2'b00);
    w(8'h04, 8'h03);
    chk({o_full_speed, o_suspend}, 2'b11);
    // Shared pin as interrupt, open drain then push-pull
    w(8'h04, 8'h23);
    i_irq_event = 1'b1;
    settle();
    chk({o_oe_int_oe, o_oe_int_out}, 2'b10);
    i_irq_event = 1'b0;
    settle();
    chk(o_oe_int_oe, 0);
    w(8'h16, 8'h03);
    chk({o_oe_int_oe, o_oe_int_out}, 2'b11);
    w(8'h16, 8'h01);
    // Back to pin control; speed and suspend pins raised together
    {i_speed_pin, i_suspend_pin} = 2'b00;
    w(8'h14, 8'h00);
    chk(o_full_speed, 0);
    w(8'h04, 8'h04);
    {i_speed_pin, i_suspend_pin, i_oe_int_in, i_dp} = 4'hf;
    settle();
    chk({o_full_speed, o_suspend, o_diff_rx_out, o_xcvr_en},
      4'hd);
    i_suspend_pin = 1'b0;
    // Transmit: data/SE0 then per-line, every pin combination
    for (int e = 1; e >= 0; e--) begin
      w(8'h04, e ? 8'h04 : 8'h00);
      i_oe_int_in = 1'b0;
      for (int k = 0; k < 4; k++) begin
        {i_sys_data_pin_b, i_sys_data_pin_a} = k[1:0];
        repeat (2) @(negedge i_sys_clk);
        if (e == 1)
          chk({o_dp, o_dm},
            k[1] ? 2'b00 : {k[0], ~k[0]});
        else
          chk({o_dp, o_dm}, {k[0], k[1]});
        chk({o_dp_oe, o_dm_oe, o_sys_data_pin_a_oe, o_sys_data_pin_b_oe},
          4'hc);
      end
    end
    // Receive: line pairs 10, 00, 01, 00 in each encoding
    for (int e = 1; e >= 0; e--) begin
      w(8'h04, e ? 8'h04 : 8'h00);
      i_oe_int_in = 1'b1;
      for (int k = 0; k < 4; k++) begin
        {i_dp, i_dm} = (k == 0) ? 2'b10 : (k == 2) ? 2'b01 : 2'b00;
        repeat (2) @(negedge i_sys_clk);
        if (e == 1)
          chk({o_sys_data_pin_a, o_sys_data_pin_b, o_diff_rx_out},
            (k < 2) ? {1'b1, k[0], 1'b1} :
            {1'b0, k[0], 1'b0});
        else
          chk({o_sys_data_pin_a, o_sys_data_pin_b, o_diff_rx_out,
            o_dplus_echo, o_dminus_echo},
            {i_dp, i_dm, k < 2, i_dp, i_dm});
        chk({o_dp_oe, o_dm_oe, o_sys_data_pin_a_oe, o_sys_data_pin_b_oe},
          4'h3);
      end
    end
    // Pass-through mode
    w(8'h04, 8'h40);
    {i_dp, i_sys_data_pin_b} = 2'b10;
    settle();
    chk({o_sys_data_pin_a, o_dm}, 2'b10);
    {i_dp, i_sys_data_pin_b} = 2'b01;
    settle();
    chk({o_sys_data_pin_a, o_dm}, 2'b01);
    // Buffer mode, both directions
    w(8'h04, 8'h04);
    w(8'h14, 8'h80);
    {i_oe_int_in, i_sys_data_pin_a, i_sys_data_pin_b} = 3'b010;
    settle();
    chk({o_dp, o_dm}, 2'b10);
    w(8'h14, 8'h98);
    {i_dp, i_dm} = 2'b10;
    settle();
    chk({o_sys_data_pin_a, o_sys_data_pin_b, o_dp_oe}, 3'b100);
    // Stalled queue fills: eight data bytes taken, ninth refused
    i_cfg_hold = 1'b1;
    M.wr(8'h04, 8'h00, 9, a);
    settle();
    chk({a[7:0], o_regs[23:16]}, 16'h0a04);
    i_cfg_hold = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    chk(o_regs[23:16], 8'h00);
    // Asynchronous register reset between clock edges
    #2 i_reset_n = 1'b0;
    #1 chk(o_regs, 24'h000001);
    @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    settle();
    complete_run();
  end
endmodule : uxc_xcvr_ctl_tb
